//--- core/pfb_pkg.sv
// shared constants, register map and helpers for the parallel flash host
package pfb_pkg;
  // clock and pin timing
  localparam int CLK_NS      = 100;
  localparam int T_ACC_NS    = 90;   // slowest read access of the part
  localparam int T_WP_NS     = 100;  // write strobe low time
  localparam int SYNC_STAGES = 2;

  // least time rounded up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACC_CYC = cyc_up(T_ACC_NS);
  localparam int WP_CYC  = cyc_up(T_WP_NS);
  localparam int CNT_W   = 4;
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(ACC_CYC + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // pin widths and bit positions
  localparam int AW      = 19;
  localparam int DW      = 16;
  localparam int A6_BIT  = 6;
  localparam int A8_BIT  = 8;
  localparam int TMO_BIT = 5;        // timeout_status_bit position

  // identification codes
  localparam logic [7:0] PROT_YES  = 8'h01;
  localparam logic [7:0] PROT_NO   = 8'h00;
  localparam logic [1:0] ID_MAKER  = 2'h0;
  localparam logic [1:0] ID_DEVICE = 2'h1;
  localparam logic [1:0] ID_PROT   = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;

  // control fields and reset values
  localparam int CTRL_WORD = 0;
  localparam int CTRL_RST  = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h1;   // word mode, reset pin released
  localparam int ADDR_LSB_BIT = 19;              // byte-mode lowest address bit

  // operation codes written to the command register
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_RESET = 3'h3;
  localparam logic [2:0] OP_HV_ID = 3'h4;

  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR  = 2;
  localparam int ST_TMO  = 3;
  localparam int ST_PROT = 4;
  localparam int ST_CONT = 5;
endpackage

//--- core/pfb_cyc_if.sv
// request and answer between the host front end and the pin cycle engine
interface pfb_cyc_if;
  import pfb_pkg::*;
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic          lsb;
  logic [DW-1:0] wdata;
  logic          word_mode;
  logic          done;
  logic [DW-1:0] rdata;

  modport ctl (output req, wr, addr, lsb, wdata, word_mode, input done, rdata);
  modport eng (input req, wr, addr, lsb, wdata, word_mode, output done, rdata);
endinterface

//--- core/pfb_cycle.sv
// pin cycle engine: one asynchronous read or write cycle on the flash pins
module pfb_cycle (
  input  logic                   clk_i,
  input  logic                   rst_i,
  pfb_cyc_if.eng                 cyc,
  input  logic [pfb_pkg::DW-1:0] dq_i,
  output logic [pfb_pkg::AW-1:0] addr_o,
  output logic [pfb_pkg::DW-1:0] dq_o,
  output logic [pfb_pkg::DW-1:0] dq_oe_o,
  output logic                   ce_n_o,
  output logic                   oe_n_o,
  output logic                   we_n_o
);
  import pfb_pkg::*;

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_RECOV} pfb_est_t;

  pfb_est_t         st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [AW-1:0]    addr_r, addr_nxt;
  logic [DW-1:0]    dq_r, dq_nxt, dqoe_r, dqoe_nxt, rdata_r, rdata_nxt;
  logic             ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt;
  logic             wr_r, wr_nxt, word_r, word_nxt, done_r, done_nxt;
  logic [DW-1:0]    s1_r, s2_r;

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser, only s2 is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
    end else begin
      s1_r <= dq_i;
      s2_r <= s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cycle sequence; strobes never overlap so the flash never sees read and write at once
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    dq_nxt    = dq_r;
    dqoe_nxt  = dqoe_r;
    rdata_nxt = rdata_r;
    ce_nxt    = ce_r;
    oe_nxt    = oe_r;
    we_nxt    = we_r;
    wr_nxt    = wr_r;
    word_nxt  = word_r;
    done_nxt  = 1'b0;
    case (st_r)
      E_IDLE: begin
        if (cyc.req) begin
          addr_nxt = cyc.addr;
          wr_nxt   = cyc.wr;
          word_nxt = cyc.word_mode;
          ce_nxt   = 1'b0;
          if (cyc.word_mode) begin
            dq_nxt   = cyc.wdata;
            dqoe_nxt = cyc.wr ? 16'hFFFF : 16'h0000;
          end else begin
            // upper lanes float, top pin carries the byte address bit
            dq_nxt   = {cyc.lsb, 7'h00, cyc.wdata[7:0]};
            dqoe_nxt = {1'b1, 7'h00, cyc.wr ? 8'hFF : 8'h00};
          end
          st_nxt = E_SETUP;
        end
      end
      E_SETUP: begin
        // address settled before the later falling strobe
        if (wr_r) begin
          we_nxt  = 1'b0;
          cnt_nxt = WR_LOAD;
        end else begin
          oe_nxt  = 1'b0;
          cnt_nxt = RD_LOAD;
        end
        st_nxt = E_STROBE;
      end
      E_STROBE: begin
        if (cnt_r == CNT_ZERO) begin
          if (wr_r) begin
            we_nxt = 1'b1;                                           // write strobe rises first
          end else begin
            rdata_nxt = word_r ? s2_r : {8'h00, s2_r[7:0]};
            oe_nxt    = 1'b1;
          end
          st_nxt = E_HOLD;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      E_HOLD: begin
        ce_nxt = 1'b1;                                               // data still held past the rise
        st_nxt = E_RECOV;
      end
      E_RECOV: begin
        dqoe_nxt = 16'h0000;
        done_nxt = 1'b1;
        st_nxt   = E_IDLE;
      end
      default: begin
        st_nxt = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= E_IDLE;
      cnt_r   <= CNT_ZERO;
      addr_r  <= 19'h00000;
      dq_r    <= 16'h0000;
      dqoe_r  <= 16'h0000;
      rdata_r <= 16'h0000;
      ce_r    <= 1'b1;
      oe_r    <= 1'b1;
      we_r    <= 1'b1;
      wr_r    <= 1'b0;
      word_r  <= 1'b1;
      done_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      dq_r    <= dq_nxt;
      dqoe_r  <= dqoe_nxt;
      rdata_r <= rdata_nxt;
      ce_r    <= ce_nxt;
      oe_r    <= oe_nxt;
      we_r    <= we_nxt;
      wr_r    <= wr_nxt;
      word_r  <= word_nxt;
      done_r  <= done_nxt;
    end
  end

  assign addr_o    = addr_r;
  assign dq_o      = dq_r;
  assign dq_oe_o   = dqoe_r;
  assign ce_n_o    = ce_r;
  assign oe_n_o    = oe_r;
  assign we_n_o    = we_r;
  assign cyc.done  = done_r;
  assign cyc.rdata = rdata_r;
endmodule

//--- core/pfb_host.sv
// host controller for an asynchronous parallel nor flash, run from wishbone registers
module pfb_host #(
  parameter logic [7:0]  CONT_CODE    = 8'h5A,      // arbitrary value, set to the part's continuation code
  parameter logic [15:0] RST_CMD_DATA = 16'h00F0
) (
  input  logic                   clk_i,
  input  logic                   rst_i,
  input  logic                   wb_cyc_i,
  input  logic                   wb_stb_i,
  input  logic                   wb_we_i,
  input  logic [7:0]             wb_adr_i,
  input  logic [3:0]             wb_sel_i,
  input  logic [31:0]            wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  logic [pfb_pkg::DW-1:0] dq_i,
  output logic [pfb_pkg::DW-1:0] dq_o,
  output logic [pfb_pkg::DW-1:0] dq_oe_o,
  output logic [pfb_pkg::AW-1:0] addr_o,
  output logic                   ce_n_o,
  output logic                   oe_n_o,
  output logic                   we_n_o,
  output logic                   reset_n_o,
  output logic                   byte_n_o,
  output logic                   elevated_pin_level_o
);
  import pfb_pkg::*;

  typedef enum logic [1:0] {T_IDLE, T_LAUNCH, T_WAIT} pfb_tst_t;

  // byte-lane merge of a register write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  pfb_cyc_if cyc ();

  pfb_tst_t      st_r, st_nxt;
  logic [1:0]    ctrl_r, ctrl_nxt;
  logic [19:0]   addr_r, addr_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic [AW-1:0] cur_r, cur_nxt;
  logic          lsb_r, lsb_nxt;
  logic [DW-1:0] out_r, out_nxt;
  logic          wr_r, wr_nxt;
  logic          hv_r, hv_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic          done_r, done_nxt, err_r, err_nxt, cont_r, cont_nxt;
  logic          ack_r, ack_nxt;
  logic [31:0]   dat_r, dat_nxt;
  logic          acc, wacc, cmd_wr;
  logic [2:0]    op;
  logic [31:0]   status_w;
  logic [31:0]   ctrl_m, addr_m, wdata_m;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign acc    = wb_cyc_i && wb_stb_i && !ack_r;
  assign wacc   = acc && wb_we_i;
  assign cmd_wr = wacc && (wb_adr_i == REG_CMD) && wb_sel_i[0];
  assign op     = wb_dat_i[2:0];

  // lane merges kept as whole words here; a function result cannot be part-selected in place
  assign ctrl_m  = lane_merge({30'h00000000, ctrl_r}, wb_dat_i, wb_sel_i);
  assign addr_m  = lane_merge({12'h000, addr_r}, wb_dat_i, wb_sel_i);
  assign wdata_m = lane_merge({16'h0000, wdata_r}, wb_dat_i, wb_sel_i);

  assign status_w = {26'h0000000,
                     cont_r,
                     rdata_r[7:0] == PROT_YES,
                     rdata_r[TMO_BIT],                             // software then sends reset
                     err_r,
                     done_r,
                     st_r != T_IDLE};

  //////////////////////////////////////////////////////////////////////////////
  // registers, operation sequencing and identification retry
  always_comb begin
    st_nxt    = st_r;
    ctrl_nxt  = ctrl_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    cur_nxt   = cur_r;
    lsb_nxt   = lsb_r;
    out_nxt   = out_r;
    wr_nxt    = wr_r;
    hv_nxt    = hv_r;
    rdata_nxt = rdata_r;
    done_nxt  = done_r;
    err_nxt   = err_r;
    cont_nxt  = cont_r;
    ack_nxt   = acc;
    dat_nxt   = 32'h00000000;
    // sticky flags: clear first so a same-cycle set below wins
    if (wacc && (wb_adr_i == REG_STATUS) && wb_sel_i[0]) begin
      if (wb_dat_i[ST_DONE]) done_nxt = 1'b0;
      if (wb_dat_i[ST_ERR])  err_nxt  = 1'b0;
      if (wb_dat_i[ST_CONT]) cont_nxt = 1'b0;
    end
    if (wacc) begin
      case (wb_adr_i)
        REG_CTRL:  ctrl_nxt  = ctrl_m[1:0];
        REG_ADDR:  addr_nxt  = addr_m[19:0];
        REG_WDATA: wdata_nxt = wdata_m[15:0];
        default: begin
        end
      endcase
    end
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL:   dat_nxt = {30'h00000000, ctrl_r};
        REG_ADDR:   dat_nxt = {12'h000, addr_r};
        REG_WDATA:  dat_nxt = {16'h0000, wdata_r};
        REG_STATUS: dat_nxt = status_w;
        REG_RDATA:  dat_nxt = {16'h0000, rdata_r};
        default:    dat_nxt = 32'h00000000;
      endcase
    end
    case (st_r)
      T_IDLE: begin
        hv_nxt = 1'b0;                                             // line 9 back to logic level
        if (cmd_wr) begin
          // flash outputs float while its reset is held, so no cycle is run
          if (ctrl_r[CTRL_RST] || !(op inside {OP_READ, OP_WRITE, OP_RESET, OP_HV_ID})) begin
            err_nxt = 1'b1;
          end else begin
            cur_nxt = addr_r[AW-1:0];
            lsb_nxt = addr_r[ADDR_LSB_BIT];
            out_nxt = (op == OP_RESET) ? RST_CMD_DATA : wdata_r;   // commands are plain writes
            wr_nxt  = (op == OP_WRITE) || (op == OP_RESET);
            if (op == OP_HV_ID) begin
              hv_nxt           = 1'b1;
              cur_nxt[A6_BIT]  = 1'b0;
            end
            st_nxt = T_LAUNCH;                                     // no set-up command needed
          end
        end
      end
      T_LAUNCH: begin
        st_nxt = T_WAIT;
      end
      T_WAIT: begin
        if (cyc.done) begin
          rdata_nxt = cyc.rdata;                                   // status or array, as returned
          if (hv_r && (cur_r[1:0] == ID_MAKER) && !cur_r[A8_BIT] && (cyc.rdata[7:0] == CONT_CODE)) begin
            cur_nxt[A8_BIT] = 1'b1;                                // reread for the real maker code
            cont_nxt        = 1'b1;
            st_nxt          = T_LAUNCH;
          end else begin
            done_nxt = 1'b1;
            st_nxt   = T_IDLE;
          end
        end
      end
      default: begin
        st_nxt = T_IDLE;
      end
    endcase
    if (cmd_wr && (st_r != T_IDLE)) begin
      err_nxt = 1'b1;                                              // busy: command dropped
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= T_IDLE;
      ctrl_r  <= CTRL_RESET_VAL;
      addr_r  <= 20'h00000;
      wdata_r <= 16'h0000;
      cur_r   <= 19'h00000;
      lsb_r   <= 1'b0;
      out_r   <= 16'h0000;
      wr_r    <= 1'b0;
      hv_r    <= 1'b0;
      rdata_r <= 16'h0000;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      cont_r  <= 1'b0;
      ack_r   <= 1'b0;
      dat_r   <= 32'h00000000;
    end else begin
      st_r    <= st_nxt;
      ctrl_r  <= ctrl_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      cur_r   <= cur_nxt;
      lsb_r   <= lsb_nxt;
      out_r   <= out_nxt;
      wr_r    <= wr_nxt;
      hv_r    <= hv_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      cont_r  <= cont_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cycle engine request and pin outputs
  assign cyc.req       = (st_r == T_LAUNCH);
  assign cyc.wr        = wr_r;
  assign cyc.addr      = cur_r;
  assign cyc.lsb       = lsb_r;
  assign cyc.wdata     = out_r;
  assign cyc.word_mode = ctrl_r[CTRL_WORD];

  // engine holds chip select high between cycles, which is standby
  pfb_cycle u_cycle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc     (cyc),
    .dq_i    (dq_i),
    .addr_o  (addr_o),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o),
    .ce_n_o  (ce_n_o),
    .oe_n_o  (oe_n_o),
    .we_n_o  (we_n_o)
  );

  assign reset_n_o            = !ctrl_r[CTRL_RST];
  assign byte_n_o             = ctrl_r[CTRL_WORD];
  assign elevated_pin_level_o = hv_r;
  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = dat_r;
endmodule

//--- tb/pfb_flash_model.sv
// behavioural flash device answering the host controller's pin cycles
module pfb_flash_model #(
  parameter logic [7:0]  CONT_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0]  MAKER     = 8'h3D,  // arbitrary value
  parameter logic [15:0] DEV_ID    = 16'h4E17 // arbitrary value
) (
  input  logic        ce_n_i,
  input  logic        oe_n_i,
  input  logic        we_n_i,
  input  logic        reset_n_i,
  input  logic        byte_n_i,
  input  logic        elev_i,
  input  logic [18:0] addr_i,
  input  logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_CMD = 8'h90;
  localparam logic [7:0] RST_CMD = 8'hF0;
  localparam logic [7:0] SUSP_CMD = 8'hB0;
  localparam logic [7:0] RES_CMD = 8'h30;
  localparam logic [7:0] STAT = 8'h48;
  logic [15:0] mem [logic [18:0]];
  logic        id_r   = 1'b0;
  logic        susp_r = 1'b0;
  logic [18:0] wa;
  logic [15:0] wv;
  logic [15:0] rv;
  wire rd_act = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
  wire wr_act = !ce_n_i && !we_n_i && oe_n_i && reset_n_i;
  ////////////////////////////////////////
  // address taken at the later falling strobe
  always @(posedge wr_act) wa = addr_i;
  // data at the earlier rising strobe; command bytes switch modes
  always @(negedge wr_act) begin
    case (dq_i[7:0])
      ID_CMD: id_r = 1'b1;
      RST_CMD: id_r = 1'b0;
      SUSP_CMD: susp_r = 1'b1;
      RES_CMD: susp_r = 1'b0;
      // strobes leaving x at the first reset edge look like a write end with no address latched
      default: if (!$isunknown(wa)) begin
        wv = mem.exists(wa) ? mem[wa] : wa[15:0] ^ 16'h5A5A;
        if (byte_n_i) wv = dq_i;
        else if (dq_i[15]) wv[15:8] = dq_i[7:0];
        else wv[7:0] = dq_i[7:0];
        mem[wa] = wv;
      end
    endcase
  end
  // reset pin drops all modes back to array reads
  always @(negedge reset_n_i) begin
    id_r = 1'b0;
    susp_r = 1'b0;
  end
  // read path; unwritten words hold an address pattern
  always @* begin
    if (id_r || (elev_i && !addr_i[6])) begin
      case (addr_i[1:0])
        2'h0: rv = {8'h00, addr_i[8] ? MAKER : CONT_CODE};
        2'h1: rv = DEV_ID;
        default: rv = {8'h00, addr_i[18:12] == 7'h00 ? 8'h01 : 8'h00};
      endcase
    end
    else if (susp_r && addr_i[18:12] == 7'h00) rv = {8'h00, STAT};
    else rv = mem.exists(addr_i) ? mem[addr_i] : addr_i[15:0] ^ 16'h5A5A;
    if (!byte_n_i) rv = {8'h00, dq_i[15] ? rv[15:8] : rv[7:0]};
    dq_o = rv;
    dq_en_o = !rd_act ? 16'h0000 : byte_n_i ? 16'hFFFF : 16'h00FF;
  end
endmodule

//--- tb/pfb_host_monitor.sv
// concurrent checks on the flash host's pins and wishbone port
module pfb_host_monitor (
  input logic                   clk_i,
  input logic                   rst_i,
  input logic                   wb_cyc_i,
  input logic                   wb_stb_i,
  input logic [31:0]            wb_dat_o,
  input logic                   wb_ack_o,
  input logic [pfb_pkg::DW-1:0] dq_o,
  input logic [pfb_pkg::DW-1:0] dq_oe_o,
  input logic [pfb_pkg::AW-1:0] addr_o,
  input logic                   ce_n_o,
  input logic                   oe_n_o,
  input logic                   we_n_o,
  input logic                   reset_n_o,
  input logic                   byte_n_o,
  input logic                   elevated_pin_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // register bus answers in exactly one cycle, one cycle long
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  // pin cycles: never read and write at once, strobes inside chip select
  a_no_rw_both: assert property (oe_n_o || we_n_o) else $error("oe and we low together");
  a_ce_leads: assert property ($fell(oe_n_o) || $fell(we_n_o) |-> !$past(ce_n_o)) else $error("ce late");
  a_write_hold: assert property ($fell(we_n_o) |-> $stable(addr_o) && $stable(dq_o) ##1
    $stable(addr_o) && $stable(dq_o) && !ce_n_o) else $error("write pins moved");
  // host keeps off the data lanes the flash drives
  a_read_float: assert property (!oe_n_o |-> dq_oe_o[14:0] == 15'h0 && dq_oe_o[15] == !byte_n_o)
    else $error("host drives read lanes");
  a_byte_lanes: assert property (!byte_n_o && !ce_n_o |-> dq_oe_o[14:8] == 7'h0 && dq_oe_o[15])
    else $error("byte lanes wrong");
  a_elev_read: assert property (elevated_pin_level_o && !ce_n_o |-> !addr_o[A6_BIT] && we_n_o)
    else $error("elevated cycle wrong");
  a_reset_quiet: assert property (!reset_n_o |-> ce_n_o && oe_n_o && we_n_o && dq_oe_o == 16'h0)
    else $error("cycle during flash reset");
endmodule

bind pfb_host pfb_host_monitor u_pfb_host_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .reset_n_o(reset_n_o),
  .byte_n_o(byte_n_o), .elevated_pin_level_o(elevated_pin_level_o));

//--- tb/tb_pfb_host.sv
// bench: host controller driving the flash model, steered over wishbone
module tb_pfb_host;
  timeunit 1ns;
  timeprecision 1ns;
  import pfb_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] st_v;
  logic [31:0] v;
  logic [15:0] h_dq, h_oe, f_dq, f_en, bus, rd;
  logic [15:0] flt_r = 16'hA5A5;
  logic [18:0] addr;
  logic        ack, ce_n, oe_n, we_n, rst_n, byte_n, elev;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc_cnt = 0;
  ////////////////////////////////////////
  initial forever #50 clk_i = ~clk_i;
  // undriven lanes toggle so a stale value never passes for data
  always @(posedge clk_i) flt_r <= ~flt_r;
  assign bus = (h_oe & h_dq) | (~h_oe & f_en & f_dq) | (~h_oe & ~f_en & flt_r);
  pfb_host u_pfb_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dq_i(bus),
    .dq_o(h_dq), .dq_oe_o(h_oe), .addr_o(addr), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .reset_n_o(rst_n), .byte_n_o(byte_n), .elevated_pin_level_o(elev));
  pfb_flash_model u_pfb_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(rst_n),
    .byte_n_i(byte_n), .elev_i(elev), .addr_i(addr), .dq_i(bus), .dq_o(f_dq), .dq_en_o(f_en));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // poll for done, keep the status, then clear done, err and retry flags
  task automatic wait_done();
    logic [31:0] x;
    do xfer(1'b0, REG_STATUS, 32'h0, st_v); while (st_v[ST_DONE] !== 1'b1);
    xfer(1'b1, REG_STATUS, 32'h26, x);
  endtask
  task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] d,
                        output logic [15:0] r);
    logic [31:0] x;
    xfer(1'b1, REG_ADDR, a, x);
    xfer(1'b1, REG_WDATA, d, x);
    xfer(1'b1, REG_CMD, {29'h0, op}, x);
    wait_done();
    xfer(1'b0, REG_RDATA, 32'h0, x);
    r = x[15:0];
  endtask
  task automatic op_chk(input logic [2:0] op, input logic [31:0] a, input logic [15:0] e);
    logic [15:0] r;
    run_op(op, a, 32'h0, r);
    check("rdata", {16'h0, r}, {16'h0, e});
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, REG_CTRL, 32'h0, v);
    check("ctrl", v, {30'h0, CTRL_RESET_VAL});
    check("byte_n", byte_n, 1'b1);
    xfer(1'b0, 8'hFC, 32'h0, v);
    check("unmapped", v, 32'h0);
    op_chk(OP_READ, 32'h10, 16'h5A4A);
    run_op(OP_WRITE, 32'h11, 32'h1234, rd);
    op_chk(OP_READ, 32'h11, 16'h1234);
    check("tmo", st_v[ST_TMO], 1'b1);
    xfer(1'b1, REG_CTRL, 32'h0, v);
    op_chk(OP_READ, 32'h80011, 16'h0012);
    op_chk(OP_READ, 32'h00011, 16'h0034);
    check("byte_n", byte_n, 1'b0);
    xfer(1'b1, REG_CTRL, 32'h1, v);
    op_chk(OP_HV_ID, 32'h000, 16'h003D);
    check("cont", st_v[ST_CONT], 1'b1);
    op_chk(OP_HV_ID, 32'h100, 16'h003D);
    op_chk(OP_HV_ID, 32'h041, 16'h4E17);
    op_chk(OP_HV_ID, 32'h002, 16'h0001);
    check("prot", st_v[ST_PROT], 1'b1);
    op_chk(OP_HV_ID, 32'h1002, 16'h0000);
    // identification by command, left again by the reset command
    run_op(OP_WRITE, 32'h555, 32'h90, rd);
    op_chk(OP_READ, 32'h001, 16'h4E17);
    run_op(OP_RESET, 32'h0, 32'h0, rd);
    op_chk(OP_READ, 32'h001, 16'h5A5B);
    // suspended sector shows status, programming in another sector still works
    run_op(OP_WRITE, 32'h0, 32'hB0, rd);
    op_chk(OP_READ, 32'h20, 16'h0048);
    op_chk(OP_READ, 32'h1020, 16'h4A7A);
    run_op(OP_WRITE, 32'h1021, 32'hBEEF, rd);
    op_chk(OP_READ, 32'h1021, 16'hBEEF);
    op_chk(OP_READ, 32'h20, 16'h0048);
    run_op(OP_WRITE, 32'h0, 32'h30, rd);
    // second command while busy is refused
    xfer(1'b1, REG_CMD, {29'h0, OP_READ}, v);
    xfer(1'b1, REG_CMD, {29'h0, OP_READ}, v);
    wait_done();
    check("err", st_v[ST_ERR], 1'b1);
    // command under flash reset is refused, pin held low
    xfer(1'b1, REG_CTRL, 32'h3, v);
    xfer(1'b1, REG_CMD, {29'h0, OP_READ}, v);
    xfer(1'b0, REG_STATUS, 32'h0, v);
    check("err", v[ST_ERR], 1'b1);
    check("reset_n", rst_n, 1'b0);
    xfer(1'b1, REG_CTRL, 32'h1, v);
    // undefined operation code is refused and runs no cycle
    xfer(1'b1, REG_STATUS, 32'h26, v);
    xfer(1'b0, REG_STATUS, 32'h0, v);
    check("err", v[ST_ERR], 1'b0);
    xfer(1'b1, REG_CMD, 32'h0, v);
    xfer(1'b0, REG_STATUS, 32'h0, v);
    check("err", v[ST_ERR], 1'b1);
    check("busy", v[ST_BUSY], 1'b0);
    // mid-run reset in byte mode with the flash reset pin low
    xfer(1'b1, REG_CTRL, 32'h2, v);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("reset_n", rst_n, 1'b1);
    check("byte_n", byte_n, 1'b1);
    xfer(1'b0, REG_CTRL, 32'h0, v);
    check("ctrl", v, {30'h0, CTRL_RESET_VAL});
    stop_test();
  end
endmodule
